// File: dpskd_defs.vh
// Constants for the DPSK dot/cross demodulator receive path.
// Assumes a single I.F. sample clock and offset-binary or two's complement ADC data.
// Function
// RULE1 - In quadrature mode the downconverter uses all four multipliers on the I and Q sample pair.
// RULE2 - In direct I.F. mode the quadrature input is forced to its zero code, so only two products count.
// RULE3 - The integrate-and-dump sums each channel over N samples, outputs the sum and restarts.
// RULE4 - The configuring party sets N so the baseband rate is twice the chip rate.
// RULE5 - The configuring party picks direct I.F. mode only for chip rates below one eighth of the sample rate.
// RULE6 - Dot is I(k)I(k-1)+Q(k)Q(k-1) and cross is Q(k)I(k-1)-I(k)Q(k-1), signed.
// RULE7 - Operands are the present symbol and the one a symbol earlier, held in a delay register.
// RULE8 - Demodulator inputs are the 8-bit matched-filter outputs at each symbol's peak-power sample.
// RULE9 - A fixed phase rotation can be applied to the previous symbol before the product.
// RULE10 - In DBPSK the decision uses only the dot sign, with no rotation.
// RULE11 - Non-negative dot gives bit 0 (no phase change), negative gives bit 1, one per symbol strobe.
`ifndef DPSKD_DEFS_VH
`define DPSKD_DEFS_VH
`define DPSKD_ADC_W 8
`define DPSKD_SYM_W 8
`define DPSKD_NCO_W 8
`define DPSKD_DEC_W 8
`define DPSKD_DEC_RST 8'h04
`define DPSKD_ROT_NONE 2'h0
`define DPSKD_ROT_P45 2'h1
`define DPSKD_ROT_M45 2'h2
`define DPSKD_BIT_SAME 1'b0
`endif

// File: dpskd_demod.v
// Downconverter, integrate-and-dump decimator and differential dot/cross demodulator.
// Assumes ADC samples and NCO words arrive asynchronous to nothing: all on i_clk_sys,
// and despread symbols arrive with a one-cycle symbol strobe from the matched filter.
// Limitation: the oscillator words are not delayed to match the two-flop sample path,
// so the oscillator must be generated on this clock with that lag in mind.
`timescale 1ns/100ps
`include "dpskd_defs.vh"
module dpskd_demod #(
   parameter ADC_W = `DPSKD_ADC_W,
   parameter NCO_W = `DPSKD_NCO_W,
   parameter DEC_W = `DPSKD_DEC_W,
   parameter ACC_W = ADC_W + NCO_W + DEC_W
) (
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire i_quad_mode,
   input wire i_adc_offset_bin,
   input wire [DEC_W-1:0] i_dec_count,
   input wire [ADC_W-1:0] i_inphase_sample_input,
   input wire [ADC_W-1:0] i_quadrature_sample_input,
   input wire signed [NCO_W-1:0] i_nco_cos,
   input wire signed [NCO_W-1:0] i_nco_sin,
   input wire i_sym_strobe,
   input wire signed [7:0] i_sym_i,
   input wire signed [7:0] i_sym_q,
   input wire [1:0] i_rot_sel,
   output reg signed [ACC_W-1:0] o_bb_i,
   output reg signed [ACC_W-1:0] o_bb_q,
   output reg o_bb_valid,
   output reg signed [17:0] o_dot,
   output reg signed [17:0] o_cross,
   output reg o_bit,
   output reg o_bit_valid
);
   // ----------------------------------------
   // Input synchronisers (external pins)
   // ----------------------------------------
   // Two flops per pin; only the second flop is read by logic
   reg quad_s1;
   reg quad_s2;
   reg offb_s1;
   reg offb_s2;
   reg [DEC_W-1:0] dec_s1;
   reg [DEC_W-1:0] dec_s2;
   reg [1:0] rot_s1;
   reg [1:0] rot_s2;
   reg [ADC_W-1:0] si_s1;
   reg [ADC_W-1:0] si_s2;
   reg [ADC_W-1:0] sq_s1;
   reg [ADC_W-1:0] sq_s2;
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         quad_s1 <= 1'b0;
         quad_s2 <= 1'b0;
         offb_s1 <= 1'b0;
         offb_s2 <= 1'b0;
         dec_s1 <= `DPSKD_DEC_RST;
         dec_s2 <= `DPSKD_DEC_RST;
         rot_s1 <= `DPSKD_ROT_NONE;
         rot_s2 <= `DPSKD_ROT_NONE;
         si_s1 <= {ADC_W{1'b0}};
         si_s2 <= {ADC_W{1'b0}};
         sq_s1 <= {ADC_W{1'b0}};
         sq_s2 <= {ADC_W{1'b0}};
      end else begin
         quad_s1 <= i_quad_mode;
         quad_s2 <= quad_s1;
         offb_s1 <= i_adc_offset_bin;
         offb_s2 <= offb_s1;
         dec_s1 <= i_dec_count;
         dec_s2 <= dec_s1;
         rot_s1 <= i_rot_sel;
         rot_s2 <= rot_s1;
         si_s1 <= i_inphase_sample_input;
         si_s2 <= si_s1;
         sq_s1 <= i_quadrature_sample_input;
         sq_s2 <= sq_s1;
      end
   end

   // ----------------------------------------
   // Complex mixer
   // ----------------------------------------
   // Offset binary becomes two's complement by flipping the MSB
   function signed [ADC_W-1:0] to_signed;
      input [ADC_W-1:0] raw;
      input offb;
      begin
         to_signed = {raw[ADC_W-1] ^ offb, raw[ADC_W-2:0]};
      end
   endfunction
   wire signed [ADC_W-1:0] xi = to_signed(si_s2, offb_s2);
   // Direct I.F. mode: Q pinned to zero code, only I*cos and I*sin remain (see RULE2)
   wire signed [ADC_W-1:0] xq = quad_s2 ? to_signed(sq_s2, offb_s2) : {ADC_W{1'b0}};
   // Four products; in direct mode the two on xq are zero (see RULE2)
   wire signed [ADC_W+NCO_W-1:0] prod_ic = xi * i_nco_cos;
   wire signed [ADC_W+NCO_W-1:0] prod_qs = xq * i_nco_sin;
   wire signed [ADC_W+NCO_W-1:0] prod_qc = xq * i_nco_cos;
   wire signed [ADC_W+NCO_W-1:0] prod_is = xi * i_nco_sin;
   // Full complex multiply by conj oscillator (see RULE1)
   wire signed [ADC_W+NCO_W:0] mix_i = prod_ic + prod_qs;
   wire signed [ADC_W+NCO_W:0] mix_q = prod_qc - prod_is;

   // ----------------------------------------
   // Integrate and dump
   // ----------------------------------------
   reg signed [ACC_W-1:0] acc_i;
   reg signed [ACC_W-1:0] acc_q;
   reg [DEC_W-1:0] dec_cnt;
   // Count is compared every cycle, so a new N acts at once;
   // a change in mid-sum shortens or stretches that one sum only
   wire dump = (dec_cnt + {{(DEC_W-1){1'b0}}, 1'b1} >= dec_s2);
   wire signed [ACC_W-1:0] mix_i_x = {{(ACC_W-ADC_W-NCO_W-1){mix_i[ADC_W+NCO_W]}}, mix_i};
   wire signed [ACC_W-1:0] mix_q_x = {{(ACC_W-ADC_W-NCO_W-1){mix_q[ADC_W+NCO_W]}}, mix_q};
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         acc_i <= {ACC_W{1'b0}};
         acc_q <= {ACC_W{1'b0}};
         dec_cnt <= {DEC_W{1'b0}};
         o_bb_i <= {ACC_W{1'b0}};
         o_bb_q <= {ACC_W{1'b0}};
         o_bb_valid <= 1'b0;
      end else begin
         o_bb_valid <= dump;
         // Sum N samples, emit and restart with no lost sample (see RULE3)
         if (dump) begin
            o_bb_i <= acc_i + mix_i_x;
            o_bb_q <= acc_q + mix_q_x;
            acc_i <= {ACC_W{1'b0}};
            acc_q <= {ACC_W{1'b0}};
            dec_cnt <= {DEC_W{1'b0}};
         end else begin
            acc_i <= acc_i + mix_i_x;
            acc_q <= acc_q + mix_q_x;
            dec_cnt <= dec_cnt + {{(DEC_W-1){1'b0}}, 1'b1};
         end
      end
   end

   // ----------------------------------------
   // Differential demodulator
   // ----------------------------------------
   // Peak-power symbol values, strobed once per symbol (see RULE8)
   reg signed [7:0] prev_i;
   reg signed [7:0] prev_q;
   reg signed [8:0] rot_i;
   reg signed [8:0] rot_q;
   // Sign extension to the rotation width
   function signed [8:0] widen;
      input signed [7:0] v;
      begin
         widen = {v[7], v};
      end
   endfunction
   // Halving rounds toward minus infinity, as a shift does
   function signed [8:0] halve;
      input signed [8:0] v;
      begin
         halve = v >>> 1;
      end
   endfunction
   // Nine bits hold every sum and difference of two 8-bit values
   wire signed [8:0] prev_i_w = widen(prev_i);
   wire signed [8:0] prev_q_w = widen(prev_q);
   wire signed [8:0] pair_sum = prev_i_w + prev_q_w;
   wire signed [8:0] pair_diff = prev_i_w - prev_q_w;
   // +45 rotates the previous symbol; -45 takes half of I+Q for I and its negation for Q; halving keeps 8-bit range except -45 Q at +128 (see RULE9)
   always @* begin
      case (rot_s2)
         `DPSKD_ROT_P45: begin
            rot_i = halve(pair_diff);
            rot_q = halve(pair_sum);
         end
         `DPSKD_ROT_M45: begin
            rot_i = halve(pair_sum);
            rot_q = -halve(pair_sum);
         end
         default: begin
            // DBPSK path: no rotation (see RULE10)
            rot_i = {prev_i[7], prev_i};
            rot_q = {prev_q[7], prev_q};
         end
      endcase
   end

   // ----------------------------------------
   // One-symbol delay register
   // ----------------------------------------
   // Zero after reset, so the first product after reset is zero (see RULE7)
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         prev_i <= 8'h00;
         prev_q <= 8'h00;
      end else if (i_sym_strobe) begin
         prev_i <= i_sym_i;
         prev_q <= i_sym_q;
      end
   end

   // ----------------------------------------
   // Products and decision
   // ----------------------------------------
   // Signed dot and cross products (see RULE6)
   wire signed [17:0] next_dot = i_sym_i * rot_i + i_sym_q * rot_q;
   wire signed [17:0] next_cross = i_sym_q * rot_i - i_sym_i * rot_q;
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_dot <= 18'h00000;
         o_cross <= 18'h00000;
         o_bit <= `DPSKD_BIT_SAME;
         o_bit_valid <= 1'b0;
      end else begin
         o_bit_valid <= i_sym_strobe;
         if (i_sym_strobe) begin
            o_dot <= next_dot;
            o_cross <= next_cross;
            // Sign of dot only; negative means a 180 degree change (see RULE11)
            o_bit <= next_dot[17];
         end
      end
   end
endmodule

// File: dpskd_adc_model.sv
// ADC pair model feeding I.F. samples.
// Assumes the Q converter is absent in direct mode.
`timescale 1ns/100ps
module dpskd_adc_model (
   input wire i_clk_sys,
   input wire i_quad_mode,
   input wire [7:0] i_lvl_i,
   input wire [7:0] i_lvl_q,
   output reg [7:0] o_inphase = 8'h00,
   output reg [7:0] o_quad = 8'h00
);
   // Absent converter toggles so a leak shows
   always @(posedge i_clk_sys) begin
      o_inphase <= i_lvl_i;
      o_quad <= i_quad_mode ? i_lvl_q : ~o_quad;
   end
endmodule

// File: dpskd_demod_monitor.sv
// Checker for the dpskd_demod decision and dump outputs.
// Assumes decimation stays at its reset value of 4.
`timescale 1ns/100ps
module dpskd_demod_monitor (
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire i_sym_strobe,
   input wire signed [7:0] i_sym_i,
   input wire signed [7:0] i_sym_q,
   input wire [1:0] i_rot_sel,
   input wire o_bb_valid,
   input wire signed [17:0] o_dot,
   input wire signed [17:0] o_cross,
   input wire o_bit,
   input wire o_bit_valid
);
   default clocking @(posedge i_clk_sys); endclocking
   default disable iff (!i_rst_b);
   reg signed [7:0] p_i, p_q;
   reg signed [17:0] e_dot, e_crs;
   reg [1:0] r1, r2;
   reg ok;
   wire signed [8:0] s = p_i + p_q;
   wire signed [8:0] ri = i_rot_sel == 2'h1 ? (p_i - p_q) >>> 1 : i_rot_sel == 2'h2 ? s >>> 1 : p_i;
   wire signed [8:0] rq = i_rot_sel == 2'h1 ? s >>> 1 : i_rot_sel == 2'h2 ? -(s >>> 1) : p_q;
   // Rotation is synced, so only trust steady settings
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         p_i <= 8'h00;
         p_q <= 8'h00;
      end else begin
         r1 <= i_rot_sel;
         r2 <= r1;
         if (i_sym_strobe) begin
            p_i <= i_sym_i;
            p_q <= i_sym_q;
            e_dot <= i_sym_i * ri + i_sym_q * rq;
            e_crs <= i_sym_q * ri - i_sym_i * rq;
            ok <= i_rot_sel == r1 && r1 == r2;
         end
      end
   end
   sequence gap_s; !o_bb_valid [*3] ##1 o_bb_valid; endsequence
   sym_answer_a: assert property (i_sym_strobe |=> o_bit_valid) else $error("no decision");
   no_strobe_a: assert property (!i_sym_strobe |=> !o_bit_valid) else $error("extra decision");
   dot_value_a: assert property (o_bit_valid && ok |-> o_dot == e_dot) else $error("dot wrong");
   cross_value_a: assert property (o_bit_valid && ok |-> o_cross == e_crs) else $error("cross wrong");
   bit_sign_a: assert property (o_bit_valid |-> o_bit == o_dot[17]) else $error("bit not sign");
   hold_out_a: assert property (!o_bit_valid |-> $stable(o_dot) && $stable(o_cross)) else $error("moved");
   dump_gap_a: assert property (o_bb_valid |=> gap_s) else $error("dump spacing");
   sym_zero_a: assert property (o_bit_valid && $past(i_sym_i) == 8'h00 && $past(i_sym_q) == 8'h00
      |-> o_dot == 18'h00000 && o_cross == 18'h00000) else $error("zero symbol");
endmodule
bind dpskd_demod dpskd_demod_monitor u_mon (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_sym_strobe(i_sym_strobe),
   .i_sym_i(i_sym_i), .i_sym_q(i_sym_q), .i_rot_sel(i_rot_sel), .o_bb_valid(o_bb_valid), .o_dot(o_dot),
   .o_cross(o_cross), .o_bit(o_bit), .o_bit_valid(o_bit_valid));

// File: test_dpskd_demod.sv
// Bench for dpskd_demod with the ADC model on the sample pins.
// Assumes cos 64, sin 32 and decimation 4.
`timescale 1ns/100ps
module test_dpskd_demod;
   reg i_clk_sys = 0, i_rst_b = 0, quad = 1, strobe = 0, offb = 0;
   reg signed [7:0] si = 0, sq = 0;
   reg [1:0] rot = 0;
   wire [7:0] ai, aq;
   wire signed [23:0] bi, bq;
   wire signed [17:0] dot, crs;
   wire bbv, bit_o, bv;
   integer bad_count = 0, checks_done = 0, k;
   reg signed [17:0] rows [0:28] = '{10,5,0,0,0, -20,3,-185,130,1, -128,-128,2176,2944,0, 127,-128,128,32640,0,
      0,0,0,0,0, 250,-250,150,450};
   dpskd_adc_model ADC (.i_clk_sys(i_clk_sys), .i_quad_mode(quad), .i_lvl_i(8'h03), .i_lvl_q(8'hFE),
      .o_inphase(ai), .o_quad(aq));
   dpskd_demod DUT (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_quad_mode(quad), .i_adc_offset_bin(offb),
      .i_dec_count(8'h04), .i_inphase_sample_input(ai), .i_quadrature_sample_input(aq), .i_nco_cos(8'h40),
      .i_nco_sin(8'h20), .i_sym_strobe(strobe), .i_sym_i(si), .i_sym_q(sq), .i_rot_sel(rot), .o_bb_i(bi),
      .o_bb_q(bq), .o_bb_valid(bbv), .o_dot(dot), .o_cross(crs), .o_bit(bit_o), .o_bit_valid(bv));
   task check(input logic [23:0] s, input logic [23:0] e);
      checks_done = checks_done + 1;
      if (s !== e) begin
         bad_count = bad_count + 1;
         $display("ERROR %0t seen %0h want %0h", $time, s, e);
      end
   endtask
   task complete_run;
      if (bad_count == 0 && checks_done > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask
   task sym(input [7:0] i, input [7:0] q);
      @(posedge i_clk_sys);
      strobe <= 1'b1;
      si <= i;
      sq <= q;
   endtask
   task drop;
      @(posedge i_clk_sys);
      strobe <= 1'b0;
      #1;
   endtask
   task dchk(input integer n);
      check(dot, rows[5 * n + 2]);
      check(crs, rows[5 * n + 3]);
      check(bit_o, rows[5 * n + 4]);
      check(bv, 1'b1);
   endtask
   task wait_dump;
      repeat (8) begin
         @(posedge i_clk_sys);
         #1;
         if (bbv === 1'b1) break;
      end
      check(bbv, 1'b1);
   endtask
   initial forever #20 i_clk_sys = ~i_clk_sys;
   initial begin
      #100000;
      bad_count = bad_count + 1;
      complete_run;
   end
   initial begin
      repeat (2) @(posedge i_clk_sys);
      #1;
      check(bv, 1'b0);
      check(dot, 18'h00000);
      @(posedge i_clk_sys);
      i_rst_b <= 1'b1;
      repeat (3) @(posedge i_clk_sys);
      for (k = 0; k < 5; k = k + 1) begin
         sym(rows[5 * k], rows[5 * k + 1]);
         #1;
         if (k > 0) dchk(k - 1);
      end
      drop;
      dchk(4);
      drop;
      check(bv, 1'b0);
      sym(8'h14, 8'h0A);
      for (k = 1; k < 3; k = k + 1) begin
         drop;
         rot <= k[1:0];
         repeat (3) @(posedge i_clk_sys);
         sym(8'h14, 8'h0A);
         drop;
         check(dot, rows[23 + 2 * k]);
         check(crs, rows[24 + 2 * k]);
      end
      repeat (2) wait_dump;
      check(bi, 24'h000200);
      check(bq, -24'sd896);
      @(posedge i_clk_sys);
      quad <= 1'b0;
      repeat (3) wait_dump;
      check(bi, 24'h000300);
      check(bq, -24'sd384);
      offb <= 1'b1;
      repeat (3) wait_dump;
      check(bi, -24'sd32000);
      check(bq, 24'sd16000);
      complete_run;
   end
endmodule
